//--- design/sbsf_top.sv
`timescale 1ns/1ps
`default_nettype none

// Operation
// - standard mode: a cpu write to the data word sets the transmit-full flag, moving it into the shifter clears it.
// - enhanced mode: transmit-full sets when a write fills the last free slot and clears once any slot frees.
// - standard mode: a received word landing in the buffer sets receive-full, a cpu read of the data word clears it.
// - enhanced mode: receive-full sets when a received word fills the last slot and clears once a slot frees.
// - frame enable turns on framed transfers with the slave select pin as frame pulse, off when zero.
// - frame sync direction one takes the pulse as input from the far master, zero drives it out as master.
// - frame sync polarity one makes the pulse active high, zero active low, for driver and receiver alike.
// - frame edge select one puts the pulse on the first bit clock, zero one bit clock ahead of it.
// - the buffer mode bit picks enhanced multi-slot when one and standard single buffer when zero.
// - transmit-full reads one while no slot is free for a write (in standard mode, while loaded data waits) and zero once room exists.
module sbsf_top
  import sbsf_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic sckIn,
  input wire logic sdiIn,
  output logic sdoOut,
  input wire logic slaveSelectPinIn,
  output logic slaveSelectPinOut,
  output logic slaveSelectPinOe
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  sbsf_pins_s pinsRaw, pinsSync;
  logic [PIN_W-1:0] pinsSyncBits;

  assign pinsRaw = '{sck: sckIn, sdi: sdiIn, ss: slaveSelectPinIn};
  assign pinsSync = sbsf_pins_s'(pinsSyncBits);

  sbsf_sync #(.WIDTH(PIN_W)) uSync (
    .clk_sys(clk_sys),
    .rst(rst),
    .ce(ce),
    .din(pinsRaw),
    .dout(pinsSyncBits)
  );

  // ----------------------------------------------------------------
  // buffers and flags
  // ----------------------------------------------------------------
  sbsf_cfg_s cfg_q, cfg_d;
  logic txInValid, txInReady, txFifoReady, txOutValid, txOutReady;
  logic rxInValid, rxInReady, rxFifoReady, rxOutValid, rxOutReady;
  logic [WORD_W-1:0] txInData, txOutData, rxInData, rxOutData;
  logic [CNT_W-1:0] txCount, rxCount;
  logic txBufferFullFlag, rxBufferFullFlag;

  // flags follow occupancy, so a set and a clear in one cycle cannot lose an event
  assign txBufferFullFlag = bufFull(cfg_q.enhancedBufferEnable, txCount);
  assign rxBufferFullFlag = bufFull(cfg_q.enhancedBufferEnable, rxCount);
  // standard mode admits one word only; the bus write stalls on it
  assign txInReady = txFifoReady && !txBufferFullFlag;
  assign rxInReady = rxFifoReady && !rxBufferFullFlag;

  sbsf_fifo #(.WIDTH(WORD_W), .DEPTH(FIFO_DEPTH)) uTxHoldingBuffer (
    .clk_sys(clk_sys),
    .rst(rst),
    .ce(ce),
    .inValid(txInValid),
    .inReady(txFifoReady),
    .inData(txInData),
    .outValid(txOutValid),
    .outReady(txOutReady),
    .outData(txOutData),
    .count(txCount)
  );

  sbsf_fifo #(.WIDTH(WORD_W), .DEPTH(FIFO_DEPTH)) uRxHoldingBuffer (
    .clk_sys(clk_sys),
    .rst(rst),
    .ce(ce),
    .inValid(rxInValid && rxInReady),
    .inReady(rxFifoReady),
    .inData(rxInData),
    .outValid(rxOutValid),
    .outReady(rxOutReady),
    .outData(rxOutData),
    .count(rxCount)
  );

  // ----------------------------------------------------------------
  // bus write side
  // ----------------------------------------------------------------
  sbsf_wr_e wrState_q, wrState_d;
  logic awHave_q, awHave_d, wHave_q, wHave_d, bvalid_q, bvalid_d;
  logic [ADDR_W-1:0] awAddr_q, awAddr_d;
  logic [WORD_W-1:0] wData_q, wData_d;
  logic [1:0] wStrb_q, wStrb_d, bresp_q, bresp_d;
  logic [WORD_W-1:0] cfgWord;

  assign s_axi_awready = ce && (wrState_q == WR_IDLE) && !awHave_q;
  assign s_axi_wready = ce && (wrState_q == WR_IDLE) && !wHave_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign txInData = wData_q;

  // address and data taken in either order, then executed together
  always_comb begin
    wrState_d = wrState_q;
    awHave_d = awHave_q;
    awAddr_d = awAddr_q;
    wHave_d = wHave_q;
    wData_d = wData_q;
    wStrb_d = wStrb_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    cfg_d = cfg_q;
    txInValid = 1'b0;
    cfgWord = cfgToWord(cfg_q);
    case (wrState_q)
      WR_IDLE: begin
        if (s_axi_awvalid && !awHave_q) begin
          awHave_d = 1'b1;
          awAddr_d = s_axi_awaddr;
        end
        if (s_axi_wvalid && !wHave_q) begin
          wHave_d = 1'b1;
          wData_d = s_axi_wdata[WORD_W-1:0];
          wStrb_d = s_axi_wstrb[1:0];
        end
        if (awHave_q && wHave_q) begin
          wrState_d = WR_EXEC;
        end
      end
      WR_EXEC: begin
        // a data write waits here while the transmit side is full
        if (decodeAddr(awAddr_q) != SEL_DATA || txInReady) begin
          awHave_d = 1'b0;
          wHave_d = 1'b0;
          bvalid_d = 1'b1;
          bresp_d = RESP_OKAY;
          wrState_d = WR_RESP;
          case (decodeAddr(awAddr_q))
            SEL_FRAMING: begin
              if (wStrb_q[1]) begin
                cfgWord[15:8] = wData_q[15:8];
              end
              if (wStrb_q[0]) begin
                cfgWord[7:0] = wData_q[7:0];
              end
              cfg_d.frameEnable = cfgWord[BIT_FRAME_EN];
              cfg_d.frameSyncDirection = cfgWord[BIT_FS_DIR];
              cfg_d.frameSyncPolarity = cfgWord[BIT_FS_POL];
              cfg_d.frameSyncEdgeSelect = cfgWord[BIT_FS_EDGE];
              cfg_d.enhancedBufferEnable = cfgWord[BIT_ENH_BUF];
            end
            SEL_DATA: txInValid = 1'b1;
            SEL_STATUS: bresp_d = RESP_OKAY;
            default: bresp_d = RESP_SLVERR;
          endcase
        end
      end
      WR_RESP: begin
        if (s_axi_bready) begin
          bvalid_d = 1'b0;
          wrState_d = WR_IDLE;
        end
      end
      default: wrState_d = WR_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wrState_q <= WR_IDLE;
      awHave_q <= 1'b0;
      awAddr_q <= '0;
      wHave_q <= 1'b0;
      wData_q <= '0;
      wStrb_q <= '0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      cfg_q <= '0;
    end else if (ce) begin
      wrState_q <= wrState_d;
      awHave_q <= awHave_d;
      awAddr_q <= awAddr_d;
      wHave_q <= wHave_d;
      wData_q <= wData_d;
      wStrb_q <= wStrb_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      cfg_q <= cfg_d;
    end
  end

  // ----------------------------------------------------------------
  // bus read side
  // ----------------------------------------------------------------
  logic rvalid_q, rvalid_d;
  logic [DATA_W-1:0] rdata_q, rdata_d;
  logic [1:0] rresp_q, rresp_d;

  assign s_axi_arready = ce && !rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  // reading the data word pops one received word; empty reads give zero
  always_comb begin
    rvalid_d = rvalid_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    rxOutReady = 1'b0;
    if (rvalid_q) begin
      if (s_axi_rready) begin
        rvalid_d = 1'b0;
      end
    end else if (s_axi_arvalid) begin
      rvalid_d = 1'b1;
      rresp_d = RESP_OKAY;
      rdata_d = '0;
      case (decodeAddr(s_axi_araddr))
        SEL_STATUS: begin
          rdata_d[BIT_TX_FULL] = txBufferFullFlag;
          rdata_d[BIT_RX_FULL] = rxBufferFullFlag;
        end
        SEL_FRAMING: rdata_d[WORD_W-1:0] = cfgToWord(cfg_q);
        SEL_DATA: begin
          rdata_d[WORD_W-1:0] = rxOutValid ? rxOutData : '0;
          rxOutReady = rxOutValid;
        end
        default: rresp_d = RESP_SLVERR;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= RESP_OKAY;
    end else if (ce) begin
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
    end
  end

  // ----------------------------------------------------------------
  // shift engine and frame pulse
  // ----------------------------------------------------------------
  sbsf_link_e linkState_q, linkState_d;
  logic [3:0] bitCnt_q, bitCnt_d;
  logic [WORD_W-1:0] shTx_q, shTx_d, shRx_q, shRx_d;
  logic loaded_q, loaded_d, loadedReal_q, loadedReal_d, sampled_q, sampled_d;
  logic fsOut_q, fsOut_d, ssOut_q, ssOut_d, sckPrev_q;
  logic sckRise, sckFall, frameMaster, fsLevelIn, pulseSeen, takeBit;

  assign sckRise = pinsSync.sck && !sckPrev_q;
  assign sckFall = !pinsSync.sck && sckPrev_q;
  assign frameMaster = cfg_q.frameEnable && !cfg_q.frameSyncDirection;
  assign fsLevelIn = cfg_q.frameSyncPolarity ? pinsSync.ss : !pinsSync.ss;
  assign pulseSeen = cfg_q.frameEnable && (frameMaster ? fsOut_q : fsLevelIn);
  assign rxInData = {shRx_q[WORD_W-2:0], pinsSync.sdi};
  assign sdoOut = shTx_q[WORD_W-1];
  assign slaveSelectPinOut = ssOut_q;
  assign slaveSelectPinOe = frameMaster;

  // sample on rising bit clock, shift out on falling, msb first
  always_comb begin
    linkState_d = linkState_q;
    bitCnt_d = bitCnt_q;
    shTx_d = shTx_q;
    shRx_d = shRx_q;
    loaded_d = loaded_q;
    loadedReal_d = loadedReal_q;
    sampled_d = sampled_q;
    fsOut_d = fsOut_q;
    txOutReady = 1'b0;
    rxInValid = 1'b0;
    takeBit = 1'b0;
    // preload so the first bit is on the pin before its clock; a zero fill is
    // swapped for real data until a bit clock arrives, else stale zeros would go out
    if (linkState_q == LK_IDLE && (!loaded_q || (!loadedReal_q && !sckRise))
        && (cfg_q.frameEnable || !pinsSync.ss)) begin
      loaded_d = 1'b1;
      sampled_d = 1'b0;
      shTx_d = txOutValid ? txOutData : '0;
      loadedReal_d = txOutValid;
      txOutReady = txOutValid;
    end
    // master pulse lasts one bit clock, launched on a falling edge
    if (!frameMaster) begin
      fsOut_d = 1'b0;
    end else if (sckFall) begin
      if (fsOut_q) begin
        fsOut_d = 1'b0;
      end else if (linkState_q == LK_IDLE && loaded_q && loadedReal_q) begin
        fsOut_d = 1'b1;
      end
    end
    case (linkState_q)
      LK_IDLE: begin
        if (sckRise && loaded_q) begin
          if (cfg_q.frameEnable) begin
            if (pulseSeen) begin
              linkState_d = LK_SHIFT;
              takeBit = cfg_q.frameSyncEdgeSelect;
            end
          end else if (!pinsSync.ss) begin
            linkState_d = LK_SHIFT;
            takeBit = 1'b1;
          end
        end
      end
      LK_SHIFT: begin
        // select released mid-word: the partial word is dropped
        if (!cfg_q.frameEnable && pinsSync.ss) begin
          linkState_d = LK_IDLE;
          bitCnt_d = '0;
          loaded_d = 1'b0;
        end else if (sckRise) begin
          takeBit = 1'b1;
        end
        if (sckFall && sampled_q) begin
          shTx_d = {shTx_q[WORD_W-2:0], 1'b0};
        end
      end
      default: linkState_d = LK_IDLE;
    endcase
    if (takeBit) begin
      shRx_d = rxInData;
      sampled_d = 1'b1;
      bitCnt_d = 4'(bitCnt_q + 1'b1);
      if (bitCnt_q == BIT_CNT_LAST) begin
        rxInValid = 1'b1;
        loaded_d = 1'b0;
        bitCnt_d = '0;
        linkState_d = LK_IDLE;
      end
    end
    ssOut_d = cfg_q.frameSyncPolarity ? fsOut_d : !fsOut_d;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      linkState_q <= LK_IDLE;
      bitCnt_q <= '0;
      shTx_q <= '0;
      shRx_q <= '0;
      loaded_q <= 1'b0;
      loadedReal_q <= 1'b0;
      sampled_q <= 1'b0;
      fsOut_q <= 1'b0;
      ssOut_q <= 1'b1;
      sckPrev_q <= 1'b0;
    end else if (ce) begin
      linkState_q <= linkState_d;
      bitCnt_q <= bitCnt_d;
      shTx_q <= shTx_d;
      shRx_q <= shRx_d;
      loaded_q <= loaded_d;
      loadedReal_q <= loadedReal_d;
      sampled_q <= sampled_d;
      fsOut_q <= fsOut_d;
      ssOut_q <= ssOut_d;
      sckPrev_q <= pinsSync.sck;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  logic txPush, txPop, rxPush, rxPop, stdMode;
  assign txPush = ce && txInValid && txInReady;
  assign txPop = ce && txOutReady;
  assign rxPush = ce && rxInValid && rxInReady;
  assign rxPop = ce && rxOutReady;
  assign stdMode = !cfg_q.enhancedBufferEnable;

  sequence frameStartEdge;
    ce && linkState_q == LK_IDLE && loaded_q && sckRise && pulseSeen;
  endsequence

  AST_TX_STD_SET: assert property (stdMode && txPush |=> txBufferFullFlag)
    else $error("transmit-full not set after write");
  AST_TX_STD_CLR: assert property (stdMode && txPop && !txPush ##1 stdMode |-> !txBufferFullFlag)
    else $error("transmit-full not cleared after load");
  AST_TX_ENH_SET: assert property (!stdMode && txCount == CNT_W'(FIFO_DEPTH-1) && txPush && !txPop
    |=> txBufferFullFlag && txCount == CNT_W'(FIFO_DEPTH))
    else $error("transmit-full not set on last slot");
  AST_TX_ENH_CLR: assert property (!stdMode && txBufferFullFlag && txPop ##1 !stdMode |-> !txBufferFullFlag)
    else $error("transmit-full held with a free slot");
  AST_RX_STD: assert property (stdMode && rxPush |=> rxBufferFullFlag)
    else $error("receive-full not set by transfer");
  AST_RX_STD_CLR: assert property (stdMode && rxPop && !rxPush ##1 stdMode |-> !rxBufferFullFlag)
    else $error("receive-full not cleared by read");
  AST_RX_ENH: assert property (!stdMode && rxCount == CNT_W'(FIFO_DEPTH-1) && rxPush && !rxPop
    |=> rxBufferFullFlag)
    else $error("receive-full not set on last slot");
  AST_RX_ENH_CLR: assert property (!stdMode && rxBufferFullFlag && rxPop ##1 !stdMode |-> !rxBufferFullFlag)
    else $error("receive-full held with a free slot");
  AST_FRAME_OFF: assert property (!cfg_q.frameEnable |-> !slaveSelectPinOe && !pulseSeen)
    else $error("frame pin driven while framing off");
  AST_FS_DIR: assert property (cfg_q.frameEnable && cfg_q.frameSyncDirection |-> !slaveSelectPinOe && !fsOut_q)
    else $error("frame pulse driven as slave");
  AST_FS_POL: assert property (ce && slaveSelectPinOe
    |=> $stable(cfg_q.frameSyncPolarity)
    |-> slaveSelectPinOut == (cfg_q.frameSyncPolarity ? fsOut_q : !fsOut_q))
    else $error("frame pulse polarity wrong");
  AST_FS_EDGE: assert property (frameStartEdge |=> linkState_q == LK_SHIFT
    && bitCnt_q == (cfg_q.frameSyncEdgeSelect ? 4'h1 : 4'h0))
    else $error("first bit placement against frame pulse wrong");
  AST_TX_FLAG: assert property ((txBufferFullFlag == bufFull(cfg_q.enhancedBufferEnable, txCount))
    and (stdMode |-> txBufferFullFlag == txOutValid))
    else $error("transmit-full disagrees with buffer");
  AST_RESET_CFG: assert property ($fell(rst) |-> cfgToWord(cfg_q) == FRAMING_RESET)
    else $error("framing bits not cleared by reset");

endmodule : sbsf_top

`default_nettype wire

//--- design/sbsf_pkg.sv
package sbsf_pkg;

  // ----------------------------------------------------------------
  // widths and depths
  // ----------------------------------------------------------------
  localparam int WORD_W = 16;
  localparam int FIFO_DEPTH = 32;
  localparam int CNT_W = 6;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int PIN_W = 3;

  // ----------------------------------------------------------------
  // register map, byte addresses on the bus
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 12'h000;
  localparam logic [ADDR_W-1:0] ADDR_FRAMING = 12'h004;
  localparam logic [ADDR_W-1:0] ADDR_DATA = 12'h008;

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int BIT_TX_FULL = 1;
  localparam int BIT_RX_FULL = 0;
  localparam int BIT_FRAME_EN = 15;
  localparam int BIT_FS_DIR = 14;
  localparam int BIT_FS_POL = 13;
  localparam int BIT_FS_EDGE = 1;
  localparam int BIT_ENH_BUF = 0;
  localparam logic [WORD_W-1:0] FRAMING_RESET = 16'h0000;
  localparam logic [3:0] BIT_CNT_LAST = 4'hF;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic frameEnable;
    logic frameSyncDirection;
    logic frameSyncPolarity;
    logic frameSyncEdgeSelect;
    logic enhancedBufferEnable;
  } sbsf_cfg_s;

  typedef struct packed {
    logic sck;
    logic sdi;
    logic ss;
  } sbsf_pins_s;

  typedef enum logic [1:0] {WR_IDLE = 2'b00, WR_EXEC = 2'b01, WR_RESP = 2'b11} sbsf_wr_e;
  typedef enum logic [1:0] {LK_IDLE = 2'b00, LK_SHIFT = 2'b01} sbsf_link_e;
  typedef enum logic [1:0] {SEL_STATUS = 2'b00, SEL_FRAMING = 2'b01, SEL_DATA = 2'b11, SEL_NONE = 2'b10} sbsf_sel_e;

  // ----------------------------------------------------------------
  // shared helpers
  // ----------------------------------------------------------------
  // low two address bits are ignored, word aligned map
  function automatic sbsf_sel_e decodeAddr(input logic [ADDR_W-1:0] addr);
    case ({addr[ADDR_W-1:2], 2'b00})
      ADDR_STATUS: decodeAddr = SEL_STATUS;
      ADDR_FRAMING: decodeAddr = SEL_FRAMING;
      ADDR_DATA: decodeAddr = SEL_DATA;
      default: decodeAddr = SEL_NONE;
    endcase
  endfunction : decodeAddr

  // full flag: one word in standard mode, every slot in enhanced mode
  function automatic logic bufFull(input logic enh, input logic [CNT_W-1:0] count);
    bufFull = enh ? (count == CNT_W'(FIFO_DEPTH)) : (count != '0);
  endfunction : bufFull

  function automatic logic [WORD_W-1:0] cfgToWord(input sbsf_cfg_s c);
    cfgToWord = FRAMING_RESET;
    cfgToWord[BIT_FRAME_EN] = c.frameEnable;
    cfgToWord[BIT_FS_DIR] = c.frameSyncDirection;
    cfgToWord[BIT_FS_POL] = c.frameSyncPolarity;
    cfgToWord[BIT_FS_EDGE] = c.frameSyncEdgeSelect;
    cfgToWord[BIT_ENH_BUF] = c.enhancedBufferEnable;
  endfunction : cfgToWord

endpackage : sbsf_pkg

//--- design/sbsf_sync.sv
`timescale 1ns/1ps
`default_nettype none

module sbsf_sync
  import sbsf_pkg::*;
#(
  parameter int WIDTH = PIN_W
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] stable_q;

  // two-stage level synchroniser; first stage feeds only the second
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      meta_q <= '0;
      stable_q <= '0;
    end else if (ce) begin
      meta_q <= din;
      stable_q <= meta_q;
    end
  end

  assign dout = stable_q;

endmodule : sbsf_sync

`default_nettype wire

//--- design/sbsf_fifo.sv
`timescale 1ns/1ps
`default_nettype none

module sbsf_fifo
  import sbsf_pkg::*;
#(
  parameter int WIDTH = WORD_W,
  parameter int DEPTH = FIFO_DEPTH
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData,
  output logic [$clog2(DEPTH+1)-1:0] count
);

  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH+1);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wrPtr_q, wrPtr_d, rdPtr_q, rdPtr_d;
  logic [CW-1:0] cnt_q, cnt_d;
  logic push, pop;

  // pointers wrap by width, so depth must be a power of two
  assign inReady = (cnt_q != CW'(DEPTH));
  assign outValid = (cnt_q != '0);
  assign outData = mem_q[rdPtr_q];
  assign count = cnt_q;
  assign push = inValid && inReady;
  assign pop = outReady && outValid;

  // next pointers and occupancy
  always_comb begin
    wrPtr_d = push ? AW'(wrPtr_q + 1'b1) : wrPtr_q;
    rdPtr_d = pop ? AW'(rdPtr_q + 1'b1) : rdPtr_q;
    cnt_d = cnt_q;
    if (push && !pop) begin
      cnt_d = CW'(cnt_q + 1'b1);
    end else if (pop && !push) begin
      cnt_d = CW'(cnt_q - 1'b1);
    end
  end

  // storage needs no reset, only pointers and count do
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      cnt_q <= '0;
    end else if (ce) begin
      wrPtr_q <= wrPtr_d;
      rdPtr_q <= rdPtr_d;
      cnt_q <= cnt_d;
      if (push) begin
        mem_q[wrPtr_q] <= inData;
      end
    end
  end

endmodule : sbsf_fifo

`default_nettype wire

//--- tb/sbsf_spi_master_model.sv
`timescale 1ns/1ps
`default_nettype none
// ---------------------------
// far-side spi master
// ---------------------------
module sbsf_spi_master_model (
  output logic sck,
  output logic sdi,
  output logic ss,
  input wire logic sdo
);
  // idle: clock still, select high
  initial begin
    sck = 1'b0;
    ss = 1'b1;
    sdi = 1'b0;
  end
  // one word msb first; data moves only while the clock is low
  task automatic xfer(input logic [15:0] w, input logic f, output logic [15:0] r);
    ss = 1'b0;
    #100;
    for (int i = 15; i >= 0; i--) begin
      sdi = w[i];
      if (f) ss = (i == 15);
      #32 sck = 1'b1;
      r = {r[14:0], sdo};
      #32 sck = 1'b0;
    end
    #64 ss = 1'b1;
    sdi = ~sdi; // released line must not look held
    #64;
  endtask : xfer
endmodule : sbsf_spi_master_model
`default_nettype wire

//--- tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
// ---------------------------
// bench top
// ---------------------------
module testbench;
  import sbsf_pkg::*;
  logic clk_sys, rst, ce, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid;
  logic arready, rvalid, sck, sdi, ss, sdo, ssOut, ssOe, ssPin;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [DATA_W-1:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic [15:0] rw;
  int err_count = 0;
  int n_compared = 0;
  // pin level: the device wins while it drives
  assign ssPin = (ssOe === 1'b1) ? ssOut : ss;
  sbsf_top sbsf_top_inst (.clk_sys(clk_sys), .rst(rst), .ce(ce), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .sckIn(sck), .sdiIn(sdi), .sdoOut(sdo), .slaveSelectPinIn(ssPin),
    .slaveSelectPinOut(ssOut), .slaveSelectPinOe(ssOe));
  sbsf_spi_master_model sbsf_spi_master_model_inst (.sck(sck), .sdi(sdi), .ss(ss), .sdo(sdo));
  // clock
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  // compare and count
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  endtask : chk
  // write: address and data offered together, each dropped once taken
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] e = RESP_OKAY);
    @(posedge clk_sys);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk(32'(bresp), 32'(e));
  endtask : wr
  // read and compare data and response
  task automatic rd(input logic [11:0] a, input logic [31:0] d, input logic [1:0] e = RESP_OKAY);
    @(posedge clk_sys);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    chk(32'(rresp), 32'(e));
    chk(rdata, d);
  endtask : rd
  task automatic close_out;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : close_out
  // watchdog, well beyond the ~50 us the tests need
  initial begin
    #300us;
    err_count++;
    $display("BAD %0t watchdog", $time);
    close_out;
  end
  // tests
  initial begin
    {rst, ce, wstrb} = 6'h3F;
    {awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata} = '0;
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    rd(ADDR_FRAMING, 32'h0);
    rd(ADDR_STATUS, 32'h0);
    wr(ADDR_FRAMING, 32'hFFFFFFFF);
    rd(ADDR_FRAMING, 32'hE003);
    wr(ADDR_FRAMING, 32'h8000);
    rd(ADDR_FRAMING, 32'h8000);
    chk(32'({ssOe, ssOut}), 32'h3);
    wr(ADDR_FRAMING, 32'hA000);
    rd(ADDR_FRAMING, 32'hA000);
    chk(32'({ssOe, ssOut}), 32'h2);
    wr(ADDR_FRAMING, 32'h0);
    wr(12'h0FC, 32'h1, RESP_SLVERR);
    rd(12'h0FC, 32'h0, RESP_SLVERR);
    $display("test registers done");
    wr(ADDR_DATA, 32'h5A3C);
    rd(ADDR_STATUS, 32'h2);
    sbsf_spi_master_model_inst.xfer(16'hC3A5, 1'b0, rw);
    chk(32'(rw), 32'h5A3C);
    rd(ADDR_STATUS, 32'h1);
    rd(ADDR_DATA, 32'hC3A5);
    rd(ADDR_STATUS, 32'h0);
    $display("test standard done");
    wr(ADDR_FRAMING, 32'hE002);
    wr(ADDR_DATA, 32'h1234);
    sbsf_spi_master_model_inst.xfer(16'hABCD, 1'b1, rw);
    chk(32'(rw), 32'h1234);
    rd(ADDR_DATA, 32'hABCD);
    $display("test framed done");
    wr(ADDR_FRAMING, 32'h1);
    for (int i = 0; i < FIFO_DEPTH; i++) begin
      wr(ADDR_DATA, 32'(i));
      if (i == FIFO_DEPTH - 2) rd(ADDR_STATUS, 32'h0);
    end
    rd(ADDR_STATUS, 32'h2);
    for (int i = 0; i < FIFO_DEPTH; i++) begin
      sbsf_spi_master_model_inst.xfer(16'hA000 + 16'(i), 1'b0, rw);
      chk(32'(rw), 32'(i));
      if (i == 0) rd(ADDR_STATUS, 32'h0);
    end
    rd(ADDR_STATUS, 32'h1);
    for (int i = 0; i < FIFO_DEPTH; i++) rd(ADDR_DATA, 32'hA000 + 32'(i));
    rd(ADDR_DATA, 32'h0);
    rd(ADDR_STATUS, 32'h0);
    $display("test enhanced done");
    close_out;
  end
endmodule : testbench
`default_nettype wire
